// file: design/aoc_pkg.sv
`default_nettype none
package aoc_pkg;
  // ===========================================
  // sizes
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned LVL_W = 6;
  // ===========================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_OUTWORD = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CH_BASE = 8'h10;
  localparam logic [7:0] OFF_CH_LAST = 8'h1C;
  localparam logic [31:0] OUTWORD_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // ===========================================
  // field positions
  localparam int unsigned CTRL_PAUSE_BIT = 0;
  localparam int unsigned STAT_EN_BIT = 0;
  localparam int unsigned STAT_EMPTY_BIT = 1;
  localparam int unsigned STAT_FULL_BIT = 2;
  localparam int unsigned STAT_LVL_LSB = 8;
  // ===========================================
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ===========================================
  // output current scale, microamps
  localparam logic [31:0] UA_ZERO = 32'h0000_0FA0;
  localparam logic [31:0] UA_SPAN = 32'h0000_3E80;
  localparam logic [31:0] CODE_MAX = 32'h0000_FFFF;
  typedef logic [15:0] code_t;
  typedef logic [14:0] ua_t;
  typedef enum logic [1:0] {
    CH_1 = 2'b00,
    CH_2 = 2'b01,
    CH_3 = 2'b10,
    CH_4 = 2'b11
  } chan_t;
  typedef struct packed {
    logic en;
    logic [12:0] rsvd;
    chan_t sel;
    code_t data;
  } host_word_t;
  function automatic ua_t code_to_ua(input code_t d);
    logic [31:0] p;
    p = (UA_SPAN * {16'h0000, d}) / CODE_MAX + UA_ZERO;
    return p[14:0];
  endfunction
endpackage
`default_nettype wire

// file: design/aoc_top.sv
`default_nettype none
// ===========================================
// fifo
module aoc_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [AW:0] level
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;
  assign level = wr_r - rd_r;
  // level counts up to depth itself, so the full test needs the extra bit
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (wr_r != rd_r);
  assign out_data = mem[rd_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
    end else if (push) begin
      wr_r <= wr_r + (AW+1)'(1);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_r <= '0;
    end else if (pop) begin
      rd_r <= rd_r + (AW+1)'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

module aoc_top (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // axi4-lite write
  input wire logic [aoc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [aoc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // channel outputs
  output logic OUT_ENABLE,
  output aoc_pkg::code_t [aoc_pkg::NUM_CH-1:0] CH_CODE,
  output aoc_pkg::ua_t [aoc_pkg::NUM_CH-1:0] CH_UA
);
  // ===========================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ===========================================
  // state
  logic aw_held_r;
  logic [aoc_pkg::ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] outword_r;
  logic [31:0] ctrl_r;
  logic en_r;
  aoc_pkg::code_t [aoc_pkg::NUM_CH-1:0] ch_r;
  aoc_pkg::ua_t [aoc_pkg::NUM_CH-1:0] ua_r;
  logic [31:0] wr_word;
  logic is_out;
  logic is_ctrl;
  logic both_held;
  logic do_write;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop_ready;
  logic [31:0] fifo_dout;
  logic [aoc_pkg::LVL_W-1:0] fifo_lvl;
  logic apply;
  aoc_pkg::host_word_t hw;
  logic [31:0] status;

  assign is_out = (aw_addr_r == aoc_pkg::OFF_OUTWORD);
  assign is_ctrl = (aw_addr_r == aoc_pkg::OFF_CTRL);
  assign both_held = aw_held_r && w_held_r && !bvalid_r;
  // a full fifo holds the write response back, stalling the master
  assign do_write = both_held && (!is_out || fifo_in_ready);
  assign fifo_in_valid = both_held && is_out;
  assign wr_word = merge(outword_r, w_data_r, w_strb_r);
  assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY = !w_held_r && !bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // ===========================================
  // write channel
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_r <= 1'b1;
      w_data_r <= S_AXI_WDATA;
      w_strb_r <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bvalid_r <= 1'b0;
      bresp_r <= aoc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= (is_out || is_ctrl) ? aoc_pkg::RESP_OKAY : aoc_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      outword_r <= aoc_pkg::OUTWORD_RST;
      ctrl_r <= aoc_pkg::CTRL_RST;
    end else if (do_write && is_out) begin
      outword_r <= wr_word;
    end else if (do_write && is_ctrl) begin
      ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_0001;
    end
  end

  // ===========================================
  // read channel
  always_comb begin
    status = '0;
    status[aoc_pkg::STAT_EN_BIT] = en_r;
    status[aoc_pkg::STAT_EMPTY_BIT] = !fifo_out_valid;
    status[aoc_pkg::STAT_FULL_BIT] = !fifo_in_ready;
    status[aoc_pkg::STAT_LVL_LSB +: aoc_pkg::LVL_W] = fifo_lvl;
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= aoc_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_r <= 1'b1;
      rresp_r <= aoc_pkg::RESP_OKAY;
      rdata_r <= '0;
      if (S_AXI_ARADDR == aoc_pkg::OFF_OUTWORD) begin
        rdata_r <= outword_r;
      end else if (S_AXI_ARADDR == aoc_pkg::OFF_CTRL) begin
        rdata_r <= ctrl_r;
      end else if (S_AXI_ARADDR == aoc_pkg::OFF_STATUS) begin
        rdata_r <= status;
      end else if (S_AXI_ARADDR >= aoc_pkg::OFF_CH_BASE && S_AXI_ARADDR <= aoc_pkg::OFF_CH_LAST
                   && S_AXI_ARADDR[1:0] == 2'b00) begin
        rdata_r <= {16'h0000, ch_r[S_AXI_ARADDR[3:2]]};
      end else begin
        rresp_r <= aoc_pkg::RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ===========================================
  // word buffer
  // host words queue here so a burst of writes is applied in order
  assign fifo_pop_ready = !ctrl_r[aoc_pkg::CTRL_PAUSE_BIT];
  aoc_fifo #(.W(aoc_pkg::WORD_W), .DEPTH(aoc_pkg::FIFO_DEPTH), .AW(aoc_pkg::LVL_W - 1)) u_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(wr_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop_ready),
    .out_data(fifo_dout),
    .level(fifo_lvl)
  );
  assign apply = fifo_out_valid && fifo_pop_ready;
  assign hw = aoc_pkg::host_word_t'(fifo_dout);

  // ===========================================
  // channel update
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      en_r <= 1'b0;
    end else if (apply) begin
      en_r <= hw.en;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ch_r <= '0;
    end else if (apply && !hw.en) begin
      ch_r <= '0;
    end else if (apply) begin
      ch_r[hw.sel] <= hw.data;
    end
  end
  // cleared codes give 4 mA until a non-zero value lands
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ua_r <= {aoc_pkg::NUM_CH{aoc_pkg::ua_t'(aoc_pkg::UA_ZERO)}};
    end else begin
      for (int i = 0; i < aoc_pkg::NUM_CH; i++) begin
        ua_r[i] <= aoc_pkg::code_to_ua(ch_r[i]);
      end
    end
  end
  assign OUT_ENABLE = en_r;
  assign CH_CODE = ch_r;
  assign CH_UA = ua_r;

  // ===========================================
  // checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  a_sel_decode: assert property (apply && hw.en && hw.sel == aoc_pkg::CH_3 |=> ch_r[2] == $past(hw.data))
    else $error("select 10 did not load channel 3");
  a_enable_update: assert property (apply && hw.en |=> en_r && ch_r[$past(hw.sel)] == $past(hw.data))
    else $error("enabled word did not update its channel");
  a_low_data: assert property (apply && hw.en && hw.sel == aoc_pkg::CH_4
    |=> ch_r[3] == $past(fifo_dout[15:0]))
    else $error("channel value is not the low 16 bits");
  a_current_map: assert property (##1 ua_r[1] == ua_t_of($past(ch_r[1])))
    else $error("channel 2 current does not follow its code");
  a_sel_field: assert property (apply && fifo_dout[31] && fifo_dout[17:16] == 2'b01
    |=> ch_r[1] == $past(fifo_dout[15:0]))
    else $error("bits 17-16 did not select channel 2");
  a_enable_bit: assert property (apply |=> en_r == $past(fifo_dout[31]))
    else $error("enable does not follow bit 31");
  a_disable_clear: assert property (apply && !hw.en |=> ch_r == '0
    ##1 ua_r[0] == aoc_pkg::ua_t'(aoc_pkg::UA_ZERO) && ua_r[3] == aoc_pkg::ua_t'(aoc_pkg::UA_ZERO))
    else $error("disable did not clear channels to 4 mA");
  a_rise_floor: assert property ($rose(en_r) && $past(hw.sel) != aoc_pkg::CH_1
    |-> ch_r[0] == '0 ##1 ua_r[0] == aoc_pkg::ua_t'(aoc_pkg::UA_ZERO))
    else $error("channel 1 left 4 mA without a write");
  a_others_keep: assert property (apply && hw.en && hw.sel != aoc_pkg::CH_1 |=> $stable(ch_r[0]))
    else $error("unselected channel changed");
  c_update_ch4: cover property (apply && hw.en && hw.sel == aoc_pkg::CH_4);
  c_disable: cover property (en_r ##1 !en_r);
  c_fifo_full: cover property (!fifo_in_ready && fifo_in_valid);
  function automatic aoc_pkg::ua_t ua_t_of(input aoc_pkg::code_t d);
    return aoc_pkg::code_to_ua(d);
  endfunction
endmodule
`default_nettype wire

// file: verif/analog_output_channel_port_tb_top.sv
`default_nettype none
module analog_output_channel_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, oen, m_en;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, w, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  aoc_pkg::code_t [3:0] code;
  aoc_pkg::ua_t [3:0] ua;
  logic [15:0] m_code [4];
  int error_cnt, cmp_count;
  aoc_top aoc_top_i (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .OUT_ENABLE(oen), .CH_CODE(code), .CH_UA(ua));
  aoc_host aoc_host_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ===========================================
  // checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [31:0] exp_ua(input logic [15:0] d);
    return 32'h0FA0 + (32'h3E80 * {16'h0000, d}) / 32'hFFFF;
  endfunction
  task automatic check_all();
    @(negedge clk);
    check(32'(oen), 32'(m_en));
    for (int c = 0; c < 4; c++) begin
      check(32'(code[c]), 32'(m_code[c]));
      check(32'(ua[c]), exp_ua(m_code[c]));
    end
    @(posedge clk);
  endtask
  task automatic send(input logic [31:0] x);
    aoc_host_i.wr(aoc_pkg::OFF_OUTWORD, x, 4'hF, resp);
    check(32'(resp), 32'(aoc_pkg::RESP_OKAY));
    m_en = x[31];
    if (!x[31])
      m_code = '{default: 16'h0000};
    else
      m_code[x[17:16]] = x[15:0];
  endtask
  // ===========================================
  // stimulus
  initial begin
    rst = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    m_en = 1'b0;
    m_code = '{default: 16'h0000};
    void'($urandom(34795));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_all();
    for (int i = 0; i < 60; i++) begin
      w = $urandom & 32'h0003FFFF;
      w[31] = (i % 9 != 8);
      if (i < 8) w[17:16] = i[1:0];
      if (i % 5 == 1) w[15:0] = 16'hFFFF;
      if (i % 7 == 2) w[15:0] = 16'h0000;
      send(w);
      repeat (2) @(posedge clk);
      check_all();
    end
    // hold the queue, fill it, then let it drain
    aoc_host_i.wr(aoc_pkg::OFF_CTRL, 32'h00000001, 4'hF, resp);
    check(32'(resp), 32'(aoc_pkg::RESP_OKAY));
    for (int i = 0; i < 32; i++) begin
      w = {1'b1, 13'h0000, i[1:0], 16'($urandom)};
      send(w);
    end
    aoc_host_i.rd(aoc_pkg::OFF_STATUS, rv, resp);
    check(32'({rv[13:8], rv[2:1]}), 32'h00000082);
    aoc_host_i.wr(aoc_pkg::OFF_CTRL, 32'h00000000, 4'hF, resp);
    repeat (40) @(posedge clk);
    check_all();
    aoc_host_i.rd(aoc_pkg::OFF_STATUS, rv, resp);
    check(32'(rv[13:0]), 32'h00000003);
    aoc_host_i.rd(aoc_pkg::OFF_CTRL, rv, resp);
    check(rv, 32'h00000000);
    // a low-half strobe must keep the stored select and enable bytes
    aoc_host_i.wr(aoc_pkg::OFF_OUTWORD, 32'hFFFF1234, 4'h3, resp);
    check(32'(resp), 32'(aoc_pkg::RESP_OKAY));
    w[15:0] = 16'h1234;
    m_code[w[17:16]] = w[15:0];
    repeat (2) @(posedge clk);
    check_all();
    aoc_host_i.rd(aoc_pkg::OFF_OUTWORD, rv, resp);
    check(rv, w);
    for (int c = 0; c < 4; c++) begin
      aoc_host_i.rd(8'(aoc_pkg::OFF_CH_BASE + 4 * c), rv, resp);
      check(rv, {16'h0000, m_code[c]});
    end
    aoc_host_i.rd(8'hFC, rv, resp);
    check({rv[29:0], resp}, {30'h00000000, aoc_pkg::RESP_SLVERR});
    aoc_host_i.wr(aoc_pkg::OFF_STATUS, 32'hFFFFFFFF, 4'hF, resp);
    check(32'(resp), 32'(aoc_pkg::RESP_SLVERR));
    test_done();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire

// file: verif/aoc_host.sv
`default_nettype none
// ===========================================
// host model: plc cpu writing output words
module aoc_host (
  // clock
  input wire logic clk,
  // write
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // ready is looked at mid-cycle, so the handshake edge is known before it comes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge clk);
      if (ah) awaddr <= ~a;
      if (ah) awvalid <= 1'b0;
      if (wh) wdata <= ~d;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) araddr <= ~a;
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire
